// [hdl/ovpc_defs.svh]
/*
 * Offsets, field positions, reset value and bus codes of the OTG line and
 * VBUS control block.
 * Assumes it is included by its bare name from every file that needs it.
 */
`ifndef OVPC_DEFS_SVH
`define OVPC_DEFS_SVH

// Register indices; the byte address is four times the index
`define OVPC_IDX_WRITE      8'h0A
`define OVPC_IDX_SET        8'h0B
`define OVPC_IDX_CLEAR      8'h0C
`define OVPC_IDX_STATUS     8'h0D
`define OVPC_ADDR_WRITE     (`OVPC_IDX_WRITE * 8'h04)
`define OVPC_ADDR_SET       (`OVPC_IDX_SET * 8'h04)
`define OVPC_ADDR_CLEAR     (`OVPC_IDX_CLEAR * 8'h04)
`define OVPC_ADDR_STATUS    (`OVPC_IDX_STATUS * 8'h04)

// Control register fields
`define OVPC_BIT_CHARGE     4
`define OVPC_BIT_DISCHARGE  3
`define OVPC_BIT_MINUS_PD   2
`define OVPC_BIT_PLUS_PD    1
`define OVPC_CTRL_RESET     8'h06
`define OVPC_CTRL_MASK      8'h1E

// Status register fields
`define OVPC_BIT_SESS_LEVEL 0
`define OVPC_BIT_SESS_ROSE  1

// Bus response codes
`define OVPC_RESP_OKAY      2'h0
`define OVPC_RESP_SLVERR    2'h2

`endif

// [hdl/ovpc_pkg.sv]
/*
 * Types shared by the register front end and the control core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ovpc_pkg;

    // One-hot register select
    typedef enum logic [4:0] {
        OVPC_SEL_NONE   = 5'h01,
        OVPC_SEL_WRITE  = 5'h02,
        OVPC_SEL_SET    = 5'h04,
        OVPC_SEL_CLEAR  = 5'h08,
        OVPC_SEL_STATUS = 5'h10
    } ovpc_sel_t;

    typedef struct packed {
        logic        valid;
        logic        hi;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } ovpc_wr_req_t;

    typedef struct packed {
        logic        valid;
        logic        hi;
        logic [7:0]  addr;
    } ovpc_rd_req_t;

    typedef struct packed {
        logic        err;
        logic [31:0] data;
    } ovpc_rd_rsp_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic        sess_meta;
        logic        sess_sync;
        logic        sess_prev;
        logic        sess_rose;
    } ovpc_core_st_t;

endpackage : ovpc_pkg

// [hdl/ovpc_axil_slave.sv]
/*
 * AXI4-Lite slave front end: takes write address and data in either order,
 * issues one write or read request to the core, returns its answer.
 * Assumes the core answers a request combinationally in the same cycle.
 */
`timescale 1ns/1ps

module ovpc_axil_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
    input  wire logic                  s_axi_awvalid_in,
    output logic                       s_axi_awready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    input  wire logic                  s_axi_wvalid_in,
    output logic                       s_axi_wready_out,
    output logic [1:0]                 s_axi_bresp_out,
    output logic                       s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
    input  wire logic                  s_axi_arvalid_in,
    output logic                       s_axi_arready_out,
    output logic [31:0]                s_axi_rdata_out,
    output logic [1:0]                 s_axi_rresp_out,
    output logic                       s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    output ovpc_pkg::ovpc_wr_req_t     wr_req_out,
    input  wire logic                  wr_err_in,
    output ovpc_pkg::ovpc_rd_req_t     rd_req_out,
    input  ovpc_pkg::ovpc_rd_rsp_t     rd_rsp_in
);
    import ovpc_pkg::*;
    `include "ovpc_defs.svh"

    typedef struct packed {
        logic              aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic              w_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } ovpc_slv_st_t;

    ovpc_slv_st_t st_r;
    ovpc_slv_st_t st_nxt;

    function automatic logic addr_hi(input logic [ADDR_W-1:0] a);
        addr_hi = (a >> 8) != '0;
    endfunction : addr_hi

    ////////////////////////////////////////////////////////////////////////
    // Handshakes; new work is held off while an answer is pending
    assign s_axi_awready_out = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready_out  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready_out = !st_r.rvalid;
    assign s_axi_bvalid_out  = st_r.bvalid;
    assign s_axi_bresp_out   = st_r.bresp;
    assign s_axi_rvalid_out  = st_r.rvalid;
    assign s_axi_rdata_out   = st_r.rdata;
    assign s_axi_rresp_out   = st_r.rresp;

    assign wr_req_out.valid = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign wr_req_out.hi    = addr_hi(st_r.awaddr);
    assign wr_req_out.addr  = st_r.awaddr[7:0];
    assign wr_req_out.data  = st_r.wdata;
    assign wr_req_out.strb  = st_r.wstrb;
    assign rd_req_out.valid = s_axi_arvalid_in && !st_r.rvalid;
    assign rd_req_out.hi    = addr_hi(s_axi_araddr_in);
    assign rd_req_out.addr  = s_axi_araddr_in[7:0];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata_in;
            st_nxt.wstrb = s_axi_wstrb_in;
        end
        if (wr_req_out.valid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = wr_err_in ? `OVPC_RESP_SLVERR : `OVPC_RESP_OKAY;
        end else if (st_r.bvalid && s_axi_bready_in) begin
            st_nxt.bvalid = 1'b0;
        end
        if (rd_req_out.valid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_rsp_in.data;
            st_nxt.rresp  = rd_rsp_in.err ? `OVPC_RESP_SLVERR : `OVPC_RESP_OKAY;
        end else if (st_r.rvalid && s_axi_rready_in) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : ovpc_axil_slave

// [hdl/ovpc_top.sv]
/*
 * OTG line and VBUS control: one 8-bit control register with write, set
 * and clear views, a synchronised session-end status, and the enables
 * for VBUS charge and discharge and the data-line pull-downs.
 * Assumes a single 200 MHz clock, synchronous active-high reset, and an
 * AXI4-Lite master that keeps at most one write and one read in flight.
 */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

module ovpc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    input  wire logic              session_end_indicator_in,
    output logic                   vbus_charge_enable_out,
    output logic                   vbus_discharge_enable_out,
    output logic                   minus_line_pulldown_enable_out,
    output logic                   plus_line_pulldown_enable_out
);
    import ovpc_pkg::*;
    `include "ovpc_defs.svh"

    ////////////////////////////////////////////////////////////////////////
    // Parameter check
    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
            $error("ADDR_W must lie between 8 and 32");
        end
    endgenerate

    ovpc_core_st_t st_r;
    ovpc_core_st_t st_nxt;
    ovpc_wr_req_t  wr_req;
    ovpc_rd_req_t  rd_req;
    ovpc_rd_rsp_t  rd_rsp;
    logic          wr_err;
    ovpc_sel_t     wr_sel;
    ovpc_sel_t     rd_sel;
    logic [7:0]    wr_bits;
    logic [7:0]    status_view;

    ////////////////////////////////////////////////////////////////////////
    // Bus front end
    ovpc_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_slave (
        .core_clk_in       (core_clk_in),
        .sys_rst_in        (sys_rst_in),
        .s_axi_awaddr_in   (s_axi_awaddr_in),
        .s_axi_awvalid_in  (s_axi_awvalid_in),
        .s_axi_awready_out (s_axi_awready_out),
        .s_axi_wdata_in    (s_axi_wdata_in),
        .s_axi_wstrb_in    (s_axi_wstrb_in),
        .s_axi_wvalid_in   (s_axi_wvalid_in),
        .s_axi_wready_out  (s_axi_wready_out),
        .s_axi_bresp_out   (s_axi_bresp_out),
        .s_axi_bvalid_out  (s_axi_bvalid_out),
        .s_axi_bready_in   (s_axi_bready_in),
        .s_axi_araddr_in   (s_axi_araddr_in),
        .s_axi_arvalid_in  (s_axi_arvalid_in),
        .s_axi_arready_out (s_axi_arready_out),
        .s_axi_rdata_out   (s_axi_rdata_out),
        .s_axi_rresp_out   (s_axi_rresp_out),
        .s_axi_rvalid_out  (s_axi_rvalid_out),
        .s_axi_rready_in   (s_axi_rready_in),
        .wr_req_out        (wr_req),
        .wr_err_in         (wr_err),
        .rd_req_out        (rd_req),
        .rd_rsp_in         (rd_rsp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by writes and reads
    function automatic ovpc_sel_t decode(input logic hi, input logic [7:0] a);
        ovpc_sel_t s;
        s = OVPC_SEL_NONE;
        if (!hi) begin
            case (a)
                `OVPC_ADDR_WRITE:  s = OVPC_SEL_WRITE;
                `OVPC_ADDR_SET:    s = OVPC_SEL_SET;
                `OVPC_ADDR_CLEAR:  s = OVPC_SEL_CLEAR;
                `OVPC_ADDR_STATUS: s = OVPC_SEL_STATUS;
                default:           s = OVPC_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    assign wr_sel  = decode(wr_req.hi, wr_req.addr);
    assign rd_sel  = decode(rd_req.hi, rd_req.addr);
    assign wr_err  = wr_req.valid && (wr_sel == OVPC_SEL_NONE);
    // Lane 0 carries the whole register; other lanes are ignored
    assign wr_bits = wr_req.strb[0] ? (wr_req.data[7:0] & `OVPC_CTRL_MASK) : 8'h00;

    always_comb begin
        status_view = 8'h00;
        status_view[`OVPC_BIT_SESS_LEVEL] = st_r.sess_sync;
        status_view[`OVPC_BIT_SESS_ROSE]  = st_r.sess_rose;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        rd_rsp = '0;
        case (rd_sel)
            OVPC_SEL_WRITE,
            OVPC_SEL_SET,
            OVPC_SEL_CLEAR:  rd_rsp.data = {24'h000000, st_r.ctrl};
            OVPC_SEL_STATUS: rd_rsp.data = {24'h000000, status_view};
            default:         rd_rsp.err  = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State update
    always_comb begin
        st_nxt = st_r;
        // Only the synchronised copy feeds the edge detector
        st_nxt.sess_meta = session_end_indicator_in;
        st_nxt.sess_sync = st_r.sess_meta;
        st_nxt.sess_prev = st_r.sess_sync;
        if (wr_req.valid) begin
            case (wr_sel)
                OVPC_SEL_WRITE: begin
                    if (wr_req.strb[0]) begin
                        st_nxt.ctrl = wr_bits;
                    end
                end
                OVPC_SEL_SET: begin
                    st_nxt.ctrl = st_r.ctrl | wr_bits;
                end
                OVPC_SEL_CLEAR: begin
                    st_nxt.ctrl = st_r.ctrl & ~wr_bits;
                end
                OVPC_SEL_STATUS: begin
                    if (wr_req.strb[0] && wr_req.data[`OVPC_BIT_SESS_ROSE]) begin
                        st_nxt.sess_rose = 1'b0;
                    end
                end
                default: begin
                    st_nxt.ctrl = st_r.ctrl;
                end
            endcase
        end
        // A rise in the clearing cycle is kept: the set wins
        if (st_r.sess_sync && !st_r.sess_prev) begin
            st_nxt.sess_rose = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_r      <= '0;
            st_r.ctrl <= `OVPC_CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog enables straight from the register, no glitching decode
    assign vbus_charge_enable_out         = st_r.ctrl[`OVPC_BIT_CHARGE];
    assign vbus_discharge_enable_out      = st_r.ctrl[`OVPC_BIT_DISCHARGE];
    assign minus_line_pulldown_enable_out = st_r.ctrl[`OVPC_BIT_MINUS_PD];
    assign plus_line_pulldown_enable_out  = st_r.ctrl[`OVPC_BIT_PLUS_PD];

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    logic wr_lane0;
    logic flag_clr;
    assign wr_lane0 = wr_req.valid && wr_req.strb[0];
    assign flag_clr = wr_lane0 && wr_sel == OVPC_SEL_STATUS && wr_req.data[`OVPC_BIT_SESS_ROSE];

    property p_write_loads;
        wr_lane0 && wr_sel == OVPC_SEL_WRITE
        |=> st_r.ctrl == ($past(wr_req.data[7:0]) & `OVPC_CTRL_MASK)
            && s_axi_bvalid_out && s_axi_bresp_out == `OVPC_RESP_OKAY;
    endproperty
    a_write_loads: assert property (p_write_loads)
        else $error("write view did not load the control register");

    property p_read_views;
        rd_req.valid && (rd_sel == OVPC_SEL_WRITE || rd_sel == OVPC_SEL_SET
                         || rd_sel == OVPC_SEL_CLEAR)
        |=> s_axi_rvalid_out && s_axi_rresp_out == `OVPC_RESP_OKAY
            && s_axi_rdata_out == {24'h000000, $past(st_r.ctrl)};
    endproperty
    a_read_views: assert property (p_read_views)
        else $error("control read view returned wrong data");

    property p_set_bits;
        wr_lane0 && wr_sel == OVPC_SEL_SET
        |=> st_r.ctrl == ($past(st_r.ctrl)
                          | ($past(wr_req.data[7:0]) & `OVPC_CTRL_MASK));
    endproperty
    a_set_bits: assert property (p_set_bits)
        else $error("set view changed the wrong bits");

    property p_clear_bits;
        wr_lane0 && wr_sel == OVPC_SEL_CLEAR
        |=> st_r.ctrl == ($past(st_r.ctrl)
                          & ~($past(wr_req.data[7:0]) & `OVPC_CTRL_MASK));
    endproperty
    a_clear_bits: assert property (p_clear_bits)
        else $error("clear view changed the wrong bits");

    property p_discharge_held;
        !wr_req.valid |=> $stable(vbus_discharge_enable_out);
    endproperty
    a_discharge_held: assert property (p_discharge_held)
        else $error("discharge enable moved without a write");

    property p_minus_pd_cause;
        $changed(minus_line_pulldown_enable_out)
        |-> $past(wr_req.valid) && $past(wr_sel) != OVPC_SEL_STATUS;
    endproperty
    a_minus_pd_cause: assert property (p_minus_pd_cause)
        else $error("minus-line pull-down moved without a control write");

    property p_plus_pd_cause;
        $changed(plus_line_pulldown_enable_out)
        |-> $past(wr_req.valid) && $past(wr_sel) != OVPC_SEL_STATUS;
    endproperty
    a_plus_pd_cause: assert property (p_plus_pd_cause)
        else $error("plus-line pull-down moved without a control write");

    property p_unmapped_err;
        wr_req.valid && wr_sel == OVPC_SEL_NONE
        |=> $stable(st_r.ctrl) && s_axi_bresp_out == `OVPC_RESP_SLVERR;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped write not refused");

    // A write-1 clear right after the rise may drop the flag on the second cycle
    property p_rise_caught;
        $rose(st_r.sess_sync) |=> st_r.sess_rose ##1 (st_r.sess_rose || $past(flag_clr));
    endproperty
    a_rise_caught: assert property (p_rise_caught)
        else $error("session-end rise not latched");

    property p_charge_cause;
        $changed(vbus_charge_enable_out)
        |-> $past(wr_req.valid) && $past(wr_sel) != OVPC_SEL_STATUS;
    endproperty
    a_charge_cause: assert property (p_charge_cause)
        else $error("charge enable moved without a control write");

    property p_strobe_off;
        wr_req.valid && !wr_req.strb[0] |=> $stable(st_r.ctrl);
    endproperty
    a_strobe_off: assert property (p_strobe_off)
        else $error("write without lane 0 changed the control register");

    property p_status_read;
        rd_req.valid && rd_sel == OVPC_SEL_STATUS
        |=> s_axi_rvalid_out && s_axi_rresp_out == `OVPC_RESP_OKAY
            && s_axi_rdata_out == {30'h0, $past(st_r.sess_rose), $past(st_r.sess_sync)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong data");

    property p_reserved_zero;
        (st_r.ctrl & ~`OVPC_CTRL_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bit stored");

    ////////////////////////////////////////////////////////////////////////
    // Coverage of main scenarios
    c_discharge_on: cover property ($rose(vbus_discharge_enable_out));
    c_discharge_done: cover property (
        vbus_discharge_enable_out && st_r.sess_rose
        ##[1:1000] !vbus_discharge_enable_out);
    c_charge_on: cover property ($rose(vbus_charge_enable_out));
    c_both_pd_off: cover property (
        !minus_line_pulldown_enable_out && !plus_line_pulldown_enable_out);

endmodule : ovpc_top

// [testbench/ovpc_vbus_model.sv]
/*
 * Behavioural VBUS node at the far side of the control block: charges and
 * discharges under the block's enables and reports session end as a level.
 * Assumes the enables come straight from the block's output pins.
 */
`timescale 1ns/1ps

module ovpc_vbus_model #(
    parameter int LEVEL_MAX = 40,
    parameter int SESS_LOW  = 8
) (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic charge_in,
    input  wire logic discharge_in,
    output logic      session_end_out
);
    import ovpc_pkg::*;

    int level_r;

    // Starts empty, so session end is high straight out of reset
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            level_r <= 0;
        end else if (discharge_in && level_r > 0) begin
            level_r <= level_r - 1;
        end else if (charge_in && !discharge_in && level_r < LEVEL_MAX) begin
            level_r <= level_r + 1;
        end
    end

    assign session_end_out = (level_r < SESS_LOW);

endmodule : ovpc_vbus_model

// [testbench/ovpc_top_bench.sv]
/*
 * Self-checking bench for the OTG line and VBUS control block: acts as the
 * link over AXI4-Lite, with a behavioural VBUS node on the far side.
 * Assumes a 200 MHz clock and the register map of ovpc_defs.svh.
 */
`timescale 1ns/1ps
`include "ovpc_defs.svh"

module ovpc_top_bench;
    import ovpc_pkg::*;

    // Short stand-in for the 2 ms single-ended-zero wait
    localparam int SE0_WAIT = 100;

    logic        clk;
    logic        rst;
    logic [7:0]  awaddr, araddr, exp_ctrl;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        sess, chg, dis, mpd, ppd;
    logic [7:0]  views [3];
    int          checks, n_mismatch, i;

    ovpc_top DUT (
        .core_clk_in(clk), .sys_rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .session_end_indicator_in(sess), .vbus_charge_enable_out(chg),
        .vbus_discharge_enable_out(dis), .minus_line_pulldown_enable_out(mpd),
        .plus_line_pulldown_enable_out(ppd)
    );

    ovpc_vbus_model vbus (
        .core_clk_in(clk), .sys_rst_in(rst), .charge_in(chg),
        .discharge_in(dis), .session_end_out(sess)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        if (a == `OVPC_ADDR_WRITE || a == `OVPC_ADDR_SET || a == `OVPC_ADDR_CLEAR) return `OVPC_RESP_OKAY;
        return (a == `OVPC_ADDR_STATUS) ? `OVPC_RESP_OKAY : `OVPC_RESP_SLVERR;
    endfunction : exp_resp

    function automatic logic [7:0] next_ctrl(input logic [7:0] cur, input logic [7:0] a,
                                             input logic [31:0] d, input logic [3:0] s);
        logic [7:0] m;
        m = d[7:0] & `OVPC_CTRL_MASK;
        if (!s[0]) return cur;
        if (a == `OVPC_ADDR_WRITE) return m;
        if (a == `OVPC_ADDR_SET) return cur | m;
        if (a == `OVPC_ADDR_CLEAR) return cur & ~m;
        return cur;
    endfunction : next_ctrl

    ////////////////////////////////////////////////////////////////////////
    // Both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // No cycle count assumed: the wait ends on bvalid, and only the watchdog bounds it
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        // Ready stays high; dropping and raising it in one step would drive it twice
        check("write response", {bvalid, bresp}, {1'b1, exp_resp(a)});
        if (a != `OVPC_ADDR_STATUS) exp_ctrl = next_ctrl(exp_ctrl, a, d, s);
        check("control pins", {chg, dis, mpd, ppd, 1'b0}, exp_ctrl[4:0]);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        check("read response", {rvalid, rresp}, {1'b1, exp_resp(a)});
    endtask : axi_rd

    task automatic rd_ctrl(input logic [7:0] a);
        axi_rd(a, rd);
        check("control read", rd, {24'h0, exp_ctrl});
    endtask : rd_ctrl

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        views = '{`OVPC_ADDR_WRITE, `OVPC_ADDR_SET, `OVPC_ADDR_CLEAR};
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wdata, wstrb} <= '0;
        rst <= 1'b1;
        void'($urandom(32'hD06B));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        exp_ctrl = `OVPC_CTRL_RESET;
        check("reset pins", {chg, dis, mpd, ppd}, 4'h3);
        for (i = 0; i < 3; i++) rd_ctrl(views[i]);
        // Empty node: session end high, rise flag set from reset
        axi_rd(`OVPC_ADDR_STATUS, rd);
        check("status after reset", rd, 32'h3);
        axi_wr(`OVPC_ADDR_STATUS, 32'h2, 4'hF);
        axi_rd(`OVPC_ADDR_STATUS, rd);
        check("status flag cleared", rd, 32'h1);
        // Charge only after discharged node and pull-downs held
        repeat (SE0_WAIT) @(posedge clk);
        axi_wr(`OVPC_ADDR_SET, 32'h10, 4'h1);
        for (i = 0; i < 200 && sess; i++) @(posedge clk);
        check("session end after charge", sess, 1'b0);
        axi_wr(`OVPC_ADDR_CLEAR, 32'h10, 4'h1);
        axi_wr(`OVPC_ADDR_STATUS, 32'h2, 4'h1);
        // Discharge until the rise is reported, then stop it
        axi_wr(`OVPC_ADDR_SET, 32'h08, 4'h1);
        for (i = 0; i < 100; i++) begin
            axi_rd(`OVPC_ADDR_STATUS, rd);
            if (rd[1] === 1'b1) break;
        end
        check("session end rise seen", rd, 32'h3);
        axi_wr(`OVPC_ADDR_CLEAR, 32'h08, 4'h1);
        // Refused and ignored accesses leave the register alone
        axi_wr(8'h38, 32'hFF, 4'hF);
        axi_rd(8'h00, rd);
        check("unmapped read data", rd, 32'h0);
        axi_wr(`OVPC_ADDR_WRITE, 32'h00, 4'hE);
        rd_ctrl(`OVPC_ADDR_CLEAR);
        // Random views, data and strobes; charge kept off as the link would
        for (i = 0; i < 80; i++) begin
            axi_wr(views[$urandom % 3], $urandom & 32'hFFFF_FFEF, 4'($urandom));
            rd_ctrl(views[$urandom % 3]);
        end
        finish_test();
    end

endmodule : ovpc_top_bench
